// file: tb/board_clock_fabric.sv
/*
  Board side model: host and agent clock pins plus the sync loop wire.
  Assumes clk runs much faster than the clock pins it produces.
*/
`timescale 1ns/100ps
`default_nettype none

module board_clock_fabric
(
  input  wire logic clk,
  input  wire logic host_mode,
  input  wire logic sync_out,
  output var  logic host_clk,
  output var  logic agent_clk,
  output logic      sync_loop
);
  // ==========================================================
  // slow pin clocks from a free counter
  logic [3:0] cnt_r   = 4'h0;
  logic       host_r  = 1'b0;
  logic       agent_r = 1'b0;

  // host pin grounded in agent mode
  always @(posedge clk)
  begin
    cnt_r <= cnt_r + 4'h1;
    host_r <= host_mode & cnt_r[2];
    agent_r <= ~host_mode & cnt_r[1];
  end

  // pins straight from the pin registers
  assign host_clk  = host_r;
  assign agent_clk = agent_r;

  // sync output looped straight back, zero skew
  assign sync_loop = sync_out;
endmodule

`default_nettype wire

// file: tb/tb_top.sv
/*
  Self-checking bench for the clock source and ratio block.
  Assumes the package clk_src_pkg and the board model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import clk_src_pkg::*;
  // ==========================================================
  // stimulus, reference state and counters
  logic       clk = 1'b0, rst_n = 1'b0, hm = 1'b1, dv = 1'b0;
  logic [3:0] code = 4'h0;
  logic [7:0] sel = 8'h00, bus_o;
  logic [4:0] ratio;
  logic       hclk, aclk, hp, ap, half, ref_o, sync_o, en_o, rsv, loop_w;
  int         n_mismatch = 0, checks_done = 0;

  always #12.5 clk = ~clk;

  board_clock_fabric u_board (.clk(clk), .host_mode(hm), .sync_out(sync_o),
    .host_clk(hclk), .agent_clk(aclk), .sync_loop(loop_w));

  bus_clock_source_and_csb_ratio u_dut (.clk(clk), .rst_n(rst_n),
    .host_primary_clock_in(hclk), .agent_bus_clock_in(aclk),
    .host_mode_strap(hm), .input_divide_strap(dv),
    .system_pll_multiplier_field(code), .bus_clock_out_divide_sel(sel),
    .primary_ref_out(ref_o), .sync_clock_out(sync_o),
    .sync_clock_out_en(en_o), .bus_clock_out(bus_o), .csb_ratio(ratio),
    .ratio_reserved(rsv));

  // expected pin samples and halved host clock
  always @(posedge clk)
  begin
    hp <= hclk;
    ap <= aclk;
    if (!rst_n || !hm) half <= 1'b0;
    else if (hclk && !hp) half <= ~half;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic do_reset(input logic m, input logic d, input logic [3:0] c);
    @(posedge clk);
    rst_n <= 1'b0;
    hm <= m;
    dv <= d;
    code <= c;
    @(posedge clk);
    @(negedge clk);
    chk(8'(en_o), 8'h01);
    chk(8'(sync_o), 8'(hp));
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  task automatic test_ratio;
    logic [7:0] e;
    for (int i = 0; i < 32; i++)
    begin
      do_reset(1'b1, i[4], i[3:0]);
      @(negedge clk);
      e = 8'h00;
      if (!i[4] && i[3:0] >= 6) e = 8'(i[3:0]);
      if (!i[4] && i[3:0] == 0) e = 8'h10;
      if (i[4] && i[3:0] >= 2 && i[3:0] <= 8) e = 8'(2 * i[3:0]);
      chk(8'(ratio), e);
      chk(8'(rsv), 8'(e == 8'h00));
    end
    $display("ratio table test done");
  endtask

  task automatic test_clk(input logic m, input logic d, input logic [7:0] s);
    @(posedge clk);
    sel <= s;
    do_reset(m, d, 4'h6);
    repeat (60)
    begin
      @(negedge clk);
      chk(8'(ref_o), 8'(m ? hp : ap));
      chk(8'(sync_o), 8'(m & (d ? half : hp)));
      chk(8'(loop_w), 8'(sync_o));
      chk(bus_o, {8{m}} & ((s & {8{half}}) | (~s & {8{hp}})));
    end
    $display("clock path test done, host %0b divide %0b", m, d);
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // main sequence
  initial
  begin
    repeat (2) @(posedge clk);
    test_ratio;
    test_clk(1'b1, 1'b0, 8'ha5);
    test_clk(1'b1, 1'b1, 8'h3c);
    test_clk(1'b0, 1'b0, 8'hff);
    report_and_stop;
  end

  // watchdog against a hang
  initial
  begin
    #125000;
    n_mismatch++;
    report_and_stop;
  end
endmodule

`default_nettype wire

// file: verilog/bus_clock_source_and_csb_ratio.sv
/*
  Clock source selection, bus clock output multiplexers and system bus
  clock ratio decode. Assumes clock pins arrive as levels synchronous to
  clk and are much slower than clk; straps are valid while rst_n is low.
*/
`timescale 1ns/100ps
`default_nettype none

module bus_clock_source_and_csb_ratio
  import clk_src_pkg::*;
#(
  parameter int unsigned N = BUS_CLK_NUM
)
(
  input  wire logic               clk,
  input  wire logic               rst_n,
  input  wire logic               host_primary_clock_in,
  input  wire logic               agent_bus_clock_in,
  input  wire logic               host_mode_strap,
  input  wire logic               input_divide_strap,
  input  wire logic [MULT_W-1:0]  system_pll_multiplier_field,
  input  wire logic [N-1:0]       bus_clock_out_divide_sel,
  output logic                    primary_ref_out,
  output logic                    sync_clock_out,
  output logic                    sync_clock_out_en,
  output logic [N-1:0]            bus_clock_out,
  output logic [RATIO_W-1:0]      csb_ratio,
  output logic                    ratio_reserved
);

  // ==========================================================
  // state
  typedef struct packed {
    logic               host_prev;
    logic               half;
    logic               host_mode;
    logic               div_strap;
    logic [MULT_W-1:0]  mult;
    logic               ref_out;
    logic               sync_out;
    logic               sync_en;
    logic [N-1:0]       bus_out;
    logic [RATIO_W-1:0] ratio;
    logic               reserved;
  } state_type;

  state_type st_r;
  state_type st_nxt;

  // ==========================================================
  // ratio decode of captured straps
  function automatic logic [RATIO_W:0] decode_ratio(
    input logic              strap,
    input logic [MULT_W-1:0] code
  );
    logic [RATIO_W:0] res;
    res = {1'b1, RATIO_RST};
    if (!strap)
    begin
      if (code >= LOW_CODE_MIN)
        res = {1'b0, 1'b0, code};
      else if (code == LOW_CODE_WRAP)
        res = {1'b0, LOW_WRAP_RATIO};
    end
    else if (code >= HIGH_CODE_MIN && code <= HIGH_CODE_MAX)
      res = {1'b0, code, 1'b0};
    return res;                                       // else
  endfunction

  // ==========================================================
  // next state
  always_comb
  begin
    logic [RATIO_W:0] dec;
    logic             host_ref;
    dec      = '0;
    host_ref = 1'b0;
    st_nxt   = st_r;
    if (!rst_n)
    begin
      // straps caught while reset is held
      st_nxt.host_mode = host_mode_strap;
      st_nxt.div_strap = input_divide_strap;
      st_nxt.mult      = system_pll_multiplier_field;
      // edge detector follows the pin in reset, so a pin that is
      // already high at release is not taken as a rising edge
      st_nxt.host_prev = host_mode_strap & host_primary_clock_in;
      st_nxt.half      = 1'b0;
      st_nxt.ref_out   = 1'b0;
      st_nxt.bus_out   = '0;
      st_nxt.ratio     = RATIO_RST;
      st_nxt.reserved  = 1'b0;
      st_nxt.sync_en   = 1'b1;
      st_nxt.sync_out  = host_primary_clock_in;
    end
    else
    begin
      host_ref = st_r.host_mode & host_primary_clock_in;
      st_nxt.host_prev = host_ref;
      // halver toggles on each sampled rising edge of the host clock
      if (host_ref && !st_r.host_prev)
        st_nxt.half = ~st_r.half;
      st_nxt.ref_out = st_r.host_mode ? host_primary_clock_in
                                      : agent_bus_clock_in;
      st_nxt.sync_out = st_r.div_strap ? st_nxt.half : host_ref;
      st_nxt.sync_en  = 1'b1;
      for (int i = 0; i < N; i++)
        st_nxt.bus_out[i] = bus_clock_out_divide_sel[i] ? st_nxt.half
                                                        : host_ref;
      dec = decode_ratio(st_r.div_strap, st_r.mult);
      st_nxt.ratio    = dec[RATIO_W-1:0];
      st_nxt.reserved = dec[RATIO_W];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    st_r <= st_nxt;
  end

  // outputs straight from the state register
  assign primary_ref_out   = st_r.ref_out;
  assign sync_clock_out    = st_r.sync_out;
  assign sync_clock_out_en = st_r.sync_en;
  assign bus_clock_out     = st_r.bus_out;
  assign csb_ratio         = st_r.ratio;
  assign ratio_reserved    = st_r.reserved;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // sampled rst_n in antecedents skips the edge that releases reset

  a_ref_host_sel: assert property (
    (rst_n && st_r.host_mode)
      |=> primary_ref_out == $past(host_primary_clock_in))
    else $error("host reference not selected");

  a_ref_agent_sel: assert property (
    (rst_n && !st_r.host_mode)
      |=> primary_ref_out == $past(agent_bus_clock_in))
    else $error("agent reference not selected");

  a_agent_outs_low: assert property (
    (rst_n && !st_r.host_mode)
      |=> bus_clock_out == '0 && !sync_clock_out)
    else $error("outputs not parked in agent mode");

  a_half_toggle: assert property (
    (rst_n && st_r.host_mode && host_primary_clock_in && !st_r.host_prev)
      |=> st_r.half != $past(st_r.half))
    else $error("halving stage missed an edge");

  a_half_hold: assert property (
    (rst_n && !(st_r.host_mode && host_primary_clock_in && !st_r.host_prev))
      |=> st_r.half == $past(st_r.half))
    else $error("halving stage toggled without an edge");

  a_sync_full: assert property (
    (rst_n && st_r.host_mode && !st_r.div_strap) ##1 1'b1
      |-> sync_clock_out == $past(host_primary_clock_in))
    else $error("sync output not undivided clock");

  a_sync_half: assert property (
    (rst_n && st_r.div_strap) ##1 st_r.div_strap
      |-> sync_clock_out == st_r.half)
    else $error("sync output not halved clock");

  // every bus clock output follows its own select bit
  for (genvar g = 0; g < N; g++)
  begin : g_bus_chk
    a_bus_sel_each: assert property (
      (rst_n && st_r.host_mode)
        |=> bus_clock_out[g] == ($past(bus_clock_out_divide_sel[g])
                                 ? st_r.half
                                 : $past(host_primary_clock_in)))
      else $error("bus clock output select wrong");
  end

  a_bus_sel_bit0: assert property (
    bus_clock_out_divide_sel[0] |=> bus_clock_out[0] == st_r.half)
    else $error("bus clock output 0 select wrong");

  a_ratio_low: assert property (
    (rst_n && !st_r.div_strap && st_r.mult >= LOW_CODE_MIN)
      |=> csb_ratio == {1'b0, $past(st_r.mult)} && !ratio_reserved)
    else $error("low strap ratio wrong");

  a_ratio_wrap: assert property (
    (rst_n && !st_r.div_strap && st_r.mult == LOW_CODE_WRAP)
      |=> csb_ratio == LOW_WRAP_RATIO && !ratio_reserved)
    else $error("low strap wrap code ratio wrong");

  a_ratio_high: assert property (
    (rst_n && st_r.div_strap && st_r.mult >= HIGH_CODE_MIN
      && st_r.mult <= HIGH_CODE_MAX)
      |=> csb_ratio == {$past(st_r.mult), 1'b0})
    else $error("high strap ratio not doubled");

  a_ratio_resv: assert property (
    (rst_n && st_r.div_strap && st_r.mult > HIGH_CODE_MAX)
      |=> ratio_reserved)
    else $error("reserved code not flagged");

  a_sync_driven: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> sync_clock_out_en)
    else $error("sync output not driven in reset");

  a_sync_in_reset: assert property (
    @(posedge clk) disable iff (1'b0)
    !rst_n |=> sync_clock_out == $past(host_primary_clock_in))
    else $error("sync output not passing clock in reset");

  c_host_half: cover property (st_r.host_mode && st_r.div_strap
                               ##1 sync_clock_out);
  c_agent: cover property (!st_r.host_mode ##1 primary_ref_out);
  c_reserved: cover property (ratio_reserved);
  c_ratio_wrap: cover property (rst_n && !st_r.div_strap
                                && st_r.mult == LOW_CODE_WRAP ##1 csb_ratio
                                == LOW_WRAP_RATIO);
  c_bus_mixed: cover property (st_r.host_mode
                               && bus_clock_out[0] != bus_clock_out[1]);

endmodule

`default_nettype wire

// file: verilog/clk_src_pkg.sv
/*
  Constants for the bus clock source and system bus clock ratio block.
  Assumes a single 40 MHz system clock; clock pins are sampled as levels.
*/
`default_nettype none

package clk_src_pkg;

  // ==========================================================
  // widths and counts
  localparam int unsigned MULT_W      = 4;
  localparam int unsigned RATIO_W     = 5;
  localparam int unsigned BUS_CLK_NUM = 8;

  // ==========================================================
  // ratio mapping limits
  localparam logic [MULT_W-1:0]  LOW_CODE_MIN  = 4'h6;
  localparam logic [MULT_W-1:0]  LOW_CODE_WRAP = 4'h0;
  localparam logic [RATIO_W-1:0] LOW_WRAP_RATIO = 5'h10;
  localparam logic [MULT_W-1:0]  HIGH_CODE_MIN = 4'h2;
  localparam logic [MULT_W-1:0]  HIGH_CODE_MAX = 4'h8;

  // ==========================================================
  // reset values
  localparam logic [RATIO_W-1:0] RATIO_RST = 5'h00;

endpackage

`default_nettype wire
